// >>> src/irrxd_consts.svh
`ifndef IRRXD_CONSTS_SVH
`define IRRXD_CONSTS_SVH

// Baud ticks per decoded bit, counter range 0..15
`define IRRXD_TICKS_PER_BIT 5'h10
`define IRRXD_CNT_MAX 4'hF
`define IRRXD_CNT_ZERO 4'h0
`define IRRXD_CNT_ONE 4'h1
// Count at which the decoded bit is presented
`define IRRXD_CNT_UPDATE 4'h8
// Count at which the next pulse window opens
`define IRRXD_CNT_WINDOW 4'hC
// Idle level of the serial line
`define IRRXD_IDLE_LEVEL 1'b1
// FIFO geometry
`define IRRXD_FIFO_WIDTH 1
`define IRRXD_FIFO_DEPTH 16
`define IRRXD_FIFO_AW 4

`endif

// >>> src/irrxd_pkg.sv
package irrxd_pkg;
  // Decoder phase within a bit period, Gray coded along the usual path
  typedef enum logic [1:0] {
    IRRXD_IDLE = 2'h0,
    IRRXD_BIT = 2'h1,
    IRRXD_HOLD = 2'h3
  } irrxd_state_t;
endpackage

// >>> src/irrxd_fifo.sv
`timescale 1ns/1ps
`include "irrxd_consts.svh"

module irrxd_fifo #(
  parameter int WIDTH = `IRRXD_FIFO_WIDTH,
  parameter int DEPTH = `IRRXD_FIFO_DEPTH,
  parameter int AW = `IRRXD_FIFO_AW
) (
  // Clocking
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    push = i_ce && i_in_valid && !full;
    pop = i_ce && i_out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    o_in_ready = !full;
    o_out_valid = !empty;
    o_out_data = mem[rd_ptr[AW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule // irrxd_fifo

// >>> src/irrxd_decoder.sv
`timescale 1ns/1ps
`include "irrxd_consts.svh"

// Operation
// - Baud tick clocks decoder, sixteen ticks per bit
// - Output bit built from tick timing, not raw
// - Enabled: pulses from pin, serial internal only
// - Local tick counter runs zero to fifteen
// - Falling input edge resets tick counter while window open
// - At count eight, present decoded bit
// - Decoded stream lags input by eight ticks
// - At count twelve, open next pulse window
module irrxd_decoder
  import irrxd_pkg::*;
(
  // Clocking
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_enable,
  input wire logic i_baud_tick,
  // Pin side
  input wire logic i_infrared_pulse_in,
  // UART side
  output logic o_uart_rxd,
  output logic o_pin_rxd_used,
  // Decoded bit stream through FIFO
  output logic o_bit_valid,
  input wire logic i_bit_ready,
  output logic o_bit_data,
  output logic o_overflow
);

  // Overview of the receive path
  // Pin level crosses into the clock domain first
  // Only a settled high-to-low change counts as a fall
  // A fall marks the start of a pulse, hence a zero bit
  // Counter advances on baud ticks only, sixteen per bit
  // Counter is forced to zero by a fall while window open
  // Count eight presents the decoded bit to the UART
  // Count twelve reopens the window for the next pulse
  // Falls before count twelve after an accepted fall are treated as ringing
  // A period with no fall decodes as a one
  // Every decoded bit is also offered to the buffer
  // Full buffer drops the bit and raises sticky overflow
  // Disable parks the counter and idles the serial line
  // Clock enable low freezes every register here

  // Pin synchroniser: stage1 only feeds stage2
  logic sync1;
  logic sync2;
  logic sync3;
  logic pin_level;
  logic next_pin_level;
  logic fall;

  // Decoder state
  irrxd_state_t state;
  irrxd_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic pulse_seen;
  logic next_pulse_seen;
  logic window_open;
  logic next_window_open;
  logic rxd;
  logic next_rxd;
  logic overflow;
  logic next_overflow;

  // Buffer handshake
  logic fifo_push;
  logic fifo_ready;

  // Three flops; a change counts once stages two and three agree
  // Filter costs three clocks of latency on every edge
  // Latency is the same for every pulse, so bit spacing holds
  // A glitch shorter than one clock never reaches pin_level
  // Hazard: pulses shorter than two clocks may be lost
  always_comb begin
    next_pin_level = (sync2 == sync3) ? sync3 : pin_level;
    fall = pin_level && !next_pin_level;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= `IRRXD_IDLE_LEVEL;
      sync2 <= `IRRXD_IDLE_LEVEL;
      sync3 <= `IRRXD_IDLE_LEVEL;
      pin_level <= `IRRXD_IDLE_LEVEL;
    end else if (i_ce) begin
      sync1 <= i_infrared_pulse_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= next_pin_level;
    end
  end

  // Bit timing; falls are caught at system rate so short pulses survive
  // Idle: counter parked at zero, waiting for a first pulse
  // Bit: counter running, window closed until count twelve
  // Hold: decoded bit shown, waiting for next pulse or wrap
  // A fall takes priority over a tick in the same cycle
  // Trade-off: realign on each pulse rather than track drift
  // Limitation: no frame check, the UART does that
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pulse_seen = pulse_seen;
    next_window_open = window_open;
    next_rxd = rxd;
    next_overflow = overflow;
    fifo_push = 1'b0;
    if (!i_enable) begin
      next_state = IRRXD_IDLE;
      next_cnt = `IRRXD_CNT_ZERO;
      next_pulse_seen = 1'b0;
      next_window_open = 1'b1;
      next_rxd = `IRRXD_IDLE_LEVEL;
    end else begin
      case (state)
        IRRXD_IDLE: begin
          // Line idles high until the first pulse starts a frame
          if (fall) begin
            next_state = IRRXD_BIT;
            next_cnt = `IRRXD_CNT_ZERO;
            next_pulse_seen = 1'b1;
            next_window_open = 1'b0;
          end
        end
        IRRXD_BIT, IRRXD_HOLD: begin
          if (fall && window_open) begin
            // Pulse in window realigns the bit period
            next_cnt = `IRRXD_CNT_ZERO;
            next_pulse_seen = 1'b1;
            next_window_open = 1'b0;
            next_state = IRRXD_BIT;
          end else if (i_baud_tick) begin
            next_cnt = (cnt == `IRRXD_CNT_MAX) ? `IRRXD_CNT_ZERO : cnt + `IRRXD_CNT_ONE;
            if (next_cnt == `IRRXD_CNT_UPDATE) begin
              // Decoded bit emerges eight ticks after its pulse
              next_rxd = !pulse_seen;
              next_pulse_seen = 1'b0;
              next_state = IRRXD_HOLD;
              fifo_push = 1'b1;
              next_overflow = overflow || !fifo_ready;
            end
            if (next_cnt == `IRRXD_CNT_WINDOW) begin
              next_window_open = 1'b1;
            end
          end
        end
        default: begin
          next_state = IRRXD_IDLE;
        end
      endcase
    end
  end

  // Decoder registers; reset idles the line high
  // Overflow clears only here, never by software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= IRRXD_IDLE;
      cnt <= `IRRXD_CNT_ZERO;
      pulse_seen <= 1'b0;
      window_open <= 1'b1;
      rxd <= `IRRXD_IDLE_LEVEL;
      overflow <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      cnt <= next_cnt;
      pulse_seen <= next_pulse_seen;
      window_open <= next_window_open;
      rxd <= next_rxd;
      overflow <= next_overflow;
    end
  end

  // UART sees only the decoder while enabled
  // Route flag simply mirrors the enable input
  always_comb begin
    o_uart_rxd = rxd;
    o_pin_rxd_used = i_enable;
    o_overflow = overflow;
  end

  // Bits are dropped, not stalled, when full: the link cannot wait
  // Pushed value is the bit that the UART sees next cycle
  // Buffer shares the clock enable, so it freezes too
  // Consumer may drain at any pace while room remains
  // Sixteen entries cover one full byte frame and more
  irrxd_fifo u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_ready),
    .i_in_data(next_rxd),
    .o_out_valid(o_bit_valid),
    .i_out_ready(i_bit_ready),
    .o_out_data(o_bit_data)
  );
endmodule // irrxd_decoder

// >>> verif/irrxd_asserts.sv
`timescale 1ns/1ps
module irrxd_asserts (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic i_baud_tick,
  input wire logic i_infrared_pulse_in,
  input wire logic o_uart_rxd,
  input wire logic o_pin_rxd_used,
  input wire logic o_bit_valid,
  input wire logic i_bit_ready,
  input wire logic o_bit_data,
  input wire logic o_overflow
);
  int tk;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Ticks since the last raw pin fall; slack covers the sync delay
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) tk <= 0;
    else if (i_ce && $fell(i_infrared_pulse_in)) tk <= 0;
    else if (i_ce && i_baud_tick) tk <= tk + 1;
  end
  sequence held_s;
    o_bit_valid && !i_bit_ready;
  endsequence
  pin_route_a: assert property (o_pin_rxd_used == i_enable) else $error("pin route wrong");
  idle_high_a: assert property (i_ce && !i_enable |=> o_uart_rxd) else $error("rxd not idle");
  rxd_lag_a: assert property ($fell(o_uart_rxd) |-> tk inside {[8:10]}) else $error("rxd lag");
  rxd_one_a: assert property ($rose(o_uart_rxd) && $past(i_enable) |-> tk inside {[24:26]})
    else $error("one bit timing");
  tick_cause_a: assert property ($changed(o_uart_rxd) && $past(i_enable) |->
    $past(i_baud_tick) || $past(i_baud_tick, 2) || $past(i_baud_tick, 3)) else $error("rxd off tick");
  hold_data_a: assert property (held_s |=> o_bit_valid && $stable(o_bit_data)) else $error("head lost");
  ovf_sticky_a: assert property (o_overflow |=> o_overflow) else $error("overflow cleared");
  ovf_cause_a: assert property ($rose(o_overflow) |-> $past(o_bit_valid)) else $error("overflow not full");
endmodule // irrxd_asserts

bind irrxd_decoder irrxd_asserts irrxd_asserts_inst (.*);

// >>> verif/irrxd_xcvr_model.sv
`timescale 1ns/1ps
module irrxd_xcvr_model (
  // Clock and tick
  input wire logic i_clk,
  input wire logic i_baud_tick,
  // Pin, idles high
  output logic o_pin
);
  logic bits[$];
  logic [3:0] ph = 4'h0;
  logic zero = 1'b0;
  // One bit per 16 ticks; a zero is a three tick low pulse
  always @(posedge i_clk) begin
    if (i_baud_tick) begin
      ph <= ph + 4'h1;
      if (ph == 4'h0) zero <= bits.size() ? !bits.pop_front() : 1'b0;
    end
  end
  assign o_pin = !(zero && ph inside {[4'h1:4'h3]});
endmodule // irrxd_xcvr_model

// >>> verif/irrxd_decoder_tb_top.sv
`timescale 1ns/1ps
module irrxd_decoder_tb_top;
  logic i_clk = 0, i_rst_n = 0, i_enable = 0, i_baud_tick = 0, i_bit_ready = 0, rdy_on = 1, ce = 1;
  logic pin, rxd, used, vld, dat, ovf;
  logic [1:0] ph = 2'h0;
  logic exp_q[$];
  integer seed = 32'h6E72066E;
  int n_mismatch = 0, cmp_count = 0, got = 0, g0;
  initial forever #20 i_clk = ~i_clk;
  irrxd_decoder irrxd_decoder_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_enable(i_enable),
    .i_baud_tick(i_baud_tick), .i_infrared_pulse_in(pin), .o_uart_rxd(rxd), .o_pin_rxd_used(used),
    .o_bit_valid(vld), .i_bit_ready(i_bit_ready), .o_bit_data(dat), .o_overflow(ovf));
  irrxd_xcvr_model irrxd_xcvr_model_inst (.i_clk(i_clk), .i_baud_tick(i_baud_tick), .o_pin(pin));
  task chk(input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for drained bits
  task wait_got(input int n);
    for (int k = 0; k < 9000 && got < n; k++) @(posedge i_clk);
    if (got < n) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Tick every fourth clock, random drain; missing bits decode as ones
  always @(posedge i_clk) begin
    ph <= ph + 2'h1;
    i_baud_tick <= ph == 2'h3;
    i_bit_ready <= rdy_on && ($random(seed) & 1);
    if (i_rst_n && vld && i_bit_ready && ce) begin
      chk(dat, exp_q.size() ? exp_q.pop_front() : 1'b1);
      got++;
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    chk(rxd, 1'b1);
    chk(vld, 1'b0);
    i_rst_n <= 1;
    i_enable <= 1;
    for (int i = 0; i < 24; i++) begin
      g0 = (i == 0) ? 0 : $random(seed);
      irrxd_xcvr_model_inst.bits.push_back(g0[0]);
      exp_q.push_back(g0[0]);
    end
    wait_got(30);
    // Stall the drain until the buffer refuses
    rdy_on <= 0;
    repeat (1300) @(posedge i_clk);
    chk(ovf, 1'b1);
    chk(vld, 1'b1);
    i_enable <= 0;
    repeat (4) @(posedge i_clk);
    chk(used, 1'b0);
    chk(rxd, 1'b1);
    // Frozen clock enable must hold the buffer
    g0 = got;
    rdy_on <= 1;
    ce <= 0;
    repeat (20) @(posedge i_clk);
    chk(got == g0, 1'b1);
    chk(vld, 1'b1);
    ce <= 1;
    wait_got(g0 + 16);
    repeat (40) @(posedge i_clk);
    chk(got == g0 + 16, 1'b1);
    chk(vld, 1'b0);
    stop_test();
  end
endmodule // irrxd_decoder_tb_top
